// [hw/ics_cfg_slave.sv]
// Configuration side of a power module: I2C slave, strap address,
// OTP load at enable, dither settings, AXI4-Lite register access.
// Assumes scl, sda, enable and strap inputs come from pins (async).
//
// Behaviour
// - Dither range 3/48 or 3/28 selectable
// - Dither period 120us or 150us, I2C settable
// - Three OTP pages, first holds factory values
// - Enable loads registers from factory page
// - Newest written page overrides factory values
// - Slave only, fast and high-speed rates
// - SDA changes only while SCL low
// - Start and stop detected while SCL high
// - Repeated start same as start; busy tracking
// - Eight bits then master-clocked acknowledge
// - Transmitter releases SDA during acknowledge
// - Seven-bit address MSB first, then direction
// - Direction zero write, one read
// - Update: address, register byte, data byte
// - Acknowledge each byte on ninth pulse
// - Register updates at falling edge after LSB
// - Strap selects address 21h to 28h
// - Defaults at enable; serial only after enable
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ics_cfg_slave #(
  parameter int DITH_SHORT_CYC = ics_pkg::DITH_SHORT_CYC,
  parameter int DITH_LONG_CYC  = ics_pkg::DITH_LONG_CYC
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Pins
  input  wire logic                        en_pin,
  input  wire logic [2:0]                  addr_sel,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output      logic                        sda_o,
  output      logic                        sda_oe,
  // OTP read port
  input  wire logic [1:0]                  otp_page_used,
  output      ics_pkg::ics_otp_rq_type     otp_rq,
  input  wire logic [7:0]                  otp_rdata,
  // Settings to the power stage
  output      logic [7:0]                  vout_code,
  output      logic                        dith_wide,
  output      logic [15:0]                 dith_period_cyc,
  // AXI4-Lite write
  input  wire logic [ics_pkg::AXI_AW-1:0]  axi_awaddr,
  input  wire logic                        axi_awvalid,
  output      logic                        axi_awready,
  input  wire logic [31:0]                 axi_wdata,
  input  wire logic [3:0]                  axi_wstrb,
  input  wire logic                        axi_wvalid,
  output      logic                        axi_wready,
  output      logic [1:0]                  axi_bresp,
  output      logic                        axi_bvalid,
  input  wire logic                        axi_bready,
  // AXI4-Lite read
  input  wire logic [ics_pkg::AXI_AW-1:0]  axi_araddr,
  input  wire logic                        axi_arvalid,
  output      logic                        axi_arready,
  output      logic [31:0]                 axi_rdata,
  output      logic [1:0]                  axi_rresp,
  output      logic                        axi_rvalid,
  input  wire logic                        axi_rready
);

  ics_pkg::ics_st_type q;
  ics_pkg::ics_st_type d;

  logic                scl_s;
  logic                sda_s;
  logic                rise;
  logic                fall;
  logic                start;
  logic                stop;
  logic                en_s;
  logic                active;
  logic [6:0]          my_addr;
  logic                aw_go;
  logic                ar_go;
  logic                ld_busy;
  logic                ld_done;
  logic [1:0]          ld_page;
  ics_pkg::ics_wr_type ld_wr;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input ics_pkg::ics_st_type s);
    return (s.ptr < 8'(ics_pkg::CFG_REGS)) ? s.cfg[s.ptr[2:0]] : 8'h00;
  endfunction

  function automatic logic is_cfg(input logic [7:0] a);
    return a < ics_pkg::OFF_STAT;
  endfunction

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  // sampling covers high-speed
  // At 100 MHz a 60 ns high-speed SCL high phase still gives several
  // samples; the two-stage synchronisers cost 20 ns of latency.
  assign scl_s   = q.scl_sy[1];
  assign sda_s   = q.sda_sy[1];
  assign en_s    = q.en_sy[1];
  assign rise    = scl_s & ~q.scl_p;
  assign fall    = ~scl_s & q.scl_p;
  assign start   = scl_s & q.scl_p & ~sda_s & q.sda_p;
  assign stop    = scl_s & q.scl_p & sda_s & ~q.sda_p;
  assign active  = en_s & q.loaded;
  assign my_addr = ics_pkg::strap_addr(q.asel_sy[5:3]);

  ics_otp_loader u_loader (
    .mclk      (mclk),
    .rst       (rst),
    .go        (en_s & ~q.en_p),
    .busy      (ld_busy),
    .done      (ld_done),
    .page_sel  (ld_page),
    .page_used (otp_page_used),
    .otp_rq    (otp_rq),
    .otp_rdata (otp_rdata),
    .wr        (ld_wr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign aw_go = axi_awvalid & axi_wvalid & ~q.bvalid;
  assign ar_go = axi_arvalid & ~q.rvalid;

  always_comb begin
    d         = q;
    d.scl_sy  = {q.scl_sy[0], scl_i};
    d.sda_sy  = {q.sda_sy[0], sda_i};
    d.scl_p   = scl_s;
    d.sda_p   = sda_s;
    d.en_sy   = {q.en_sy[0], en_pin};
    d.en_p    = en_s;
    d.asel_sy = {q.asel_sy[2:0], addr_sel};

    // AXI write; loader and I2C below take priority
    if (q.bvalid && axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (aw_go) begin
      d.bvalid = 1'b1;
      d.bresp  = ics_pkg::RESP_OK;
      if (is_cfg(axi_awaddr)) begin
        if (axi_wstrb[0] && !ld_busy) begin
          d.cfg[axi_awaddr[4:2]] = axi_wdata[7:0];
        end
      end else if (axi_awaddr != ics_pkg::OFF_STAT) begin
        d.bresp = ics_pkg::RESP_SLVERR;
      end
    end

    // AXI read
    if (q.rvalid && axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_go) begin
      d.rvalid = 1'b1;
      d.rresp  = ics_pkg::RESP_OK;
      d.rdata  = 32'h0;
      if (is_cfg(axi_araddr)) begin
        d.rdata[7:0] = q.cfg[axi_araddr[4:2]];
      end else if (axi_araddr == ics_pkg::OFF_STAT) begin
        d.rdata[0] = q.loaded;
        d.rdata[1] = ld_busy;
        d.rdata[2] = q.busy;
        d.rdata[ics_pkg::ST_ADDR_LSB +: 7] = my_addr;
        d.rdata[ics_pkg::ST_PAGE_LSB +: 2] = ld_page;
      end else begin
        d.rresp = ics_pkg::RESP_SLVERR;
      end
    end

    if (ld_wr.en) begin
      d.cfg[ld_wr.idx] = ld_wr.data;
    end
    if (en_s && !q.en_p) begin
      d.loaded = 1'b0;
    end else if (ld_done) begin
      d.loaded = 1'b1;
    end
    if (!en_s) begin
      d.loaded = 1'b0;
    end

    // I2C engine
    if (!active) begin
      d.ph     = ics_pkg::PH_IDLE;
      d.sda_oe = 1'b0;
      d.busy   = 1'b0;
    end else if (start) begin
      d.ph     = ics_pkg::PH_ADDR;
      // The SCL fall that ends the start is no bit: it wraps this to 0
      d.bcnt   = 4'hf;
      d.sda_oe = 1'b0;
      d.busy   = 1'b1;
    end else if (stop) begin
      d.ph     = ics_pkg::PH_IDLE;
      d.sda_oe = 1'b0;
      d.busy   = 1'b0;
    end else if (q.ph != ics_pkg::PH_IDLE && q.ph != ics_pkg::PH_SKIP) begin
      if (rise && q.bcnt < 4'h8) begin
        d.sh = {q.sh[6:0], sda_s};
      end
      // Master not acknowledging a read byte ends our part
      if (rise && q.bcnt == 4'h8 && q.ph == ics_pkg::PH_RD && sda_s) begin
        d.ph = ics_pkg::PH_SKIP;
      end
      if (fall) begin
        if (q.bcnt == 4'h7) begin
          d.bcnt = 4'h8;
          case (q.ph)
            ics_pkg::PH_ADDR: begin
              if (q.sh[7:1] == my_addr) begin
                d.sda_oe = 1'b1;
                d.rd     = q.sh[0];
              end else begin
                d.ph     = ics_pkg::PH_SKIP;
              end
            end
            ics_pkg::PH_REG: begin
              d.sda_oe = 1'b1;
              d.ptr    = q.sh;
            end
            ics_pkg::PH_DATA: begin
              d.sda_oe = 1'b1;
              if (q.ptr < 8'(ics_pkg::CFG_REGS)) begin
                d.cfg[q.ptr[2:0]] = q.sh;
              end
            end
            default: begin
              d.sda_oe = 1'b0;
            end
          endcase
        end else if (q.bcnt == 4'h8) begin
          d.bcnt   = 4'h0;
          d.sda_oe = 1'b0;
          case (q.ph)
            ics_pkg::PH_ADDR: begin
              if (q.rd) begin
                d.ph     = ics_pkg::PH_RD;
                d.tx     = rd_byte(q);
                d.sda_oe = ~d.tx[7];
              end else begin
                d.ph = ics_pkg::PH_REG;
              end
            end
            ics_pkg::PH_REG: begin
              d.ph = ics_pkg::PH_DATA;
            end
            ics_pkg::PH_RD: begin
              d.tx     = rd_byte(q);
              d.sda_oe = ~d.tx[7];
            end
            default: begin
              // One byte per update; further bytes go unanswered
              d.ph = ics_pkg::PH_SKIP;
            end
          endcase
        end else begin
          d.bcnt = q.bcnt + 4'h1;
          if (q.ph == ics_pkg::PH_RD) begin
            d.tx     = {q.tx[6:0], 1'b0};
            d.sda_oe = ~q.tx[6];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.scl_sy <= 2'h3;
      q.sda_sy <= 2'h3;
      q.scl_p  <= 1'b1;
      q.sda_p  <= 1'b1;
      q.cfg[ics_pkg::REG_VOUT] <= ics_pkg::VOUT_5V_RST;
      q.cfg[ics_pkg::REG_DITH] <= ics_pkg::DITH_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low
  assign sda_o       = 1'b0;
  assign sda_oe      = q.sda_oe;
  assign vout_code   = q.cfg[ics_pkg::REG_VOUT];
  assign dith_wide   = q.cfg[ics_pkg::REG_DITH][ics_pkg::DITH_WIDE_BIT];
  assign dith_period_cyc = q.cfg[ics_pkg::REG_DITH][ics_pkg::DITH_SLOW_BIT]
                         ? 16'(DITH_LONG_CYC) : 16'(DITH_SHORT_CYC);
  assign axi_awready = aw_go;
  assign axi_wready  = aw_go;
  assign axi_bvalid  = q.bvalid;
  assign axi_bresp   = q.bresp;
  assign axi_arready = ar_go;
  assign axi_rvalid  = q.rvalid;
  assign axi_rresp   = q.rresp;
  assign axi_rdata   = q.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  logic byte_end;
  assign byte_end = active && !start && !stop && fall && q.bcnt == 4'h7;

  a_addr_ack: assert property (
    (byte_end && q.ph == ics_pkg::PH_ADDR && q.sh[7:1] == my_addr)
    |=> q.sda_oe && q.bcnt == 4'h8)
    else $error("matching address not acknowledged");

  a_addr_nack: assert property (
    (byte_end && q.ph == ics_pkg::PH_ADDR && q.sh[7:1] != my_addr)
    |=> q.ph == ics_pkg::PH_SKIP && !q.sda_oe)
    else $error("foreign address answered");

  a_lsb_write: assert property (
    (byte_end && q.ph == ics_pkg::PH_DATA && q.ptr < 8'h08)
    |=> q.cfg[$past(q.ptr[2:0])] == $past(q.sh))
    else $error("data byte not stored at LSB fall");

  a_start_busy: assert property (
    (active && start) |=> q.ph == ics_pkg::PH_ADDR && q.busy && !q.sda_oe)
    else $error("start not taken");

  a_stop_free: assert property (
    (active && stop && !start) |=> !q.busy && q.ph == ics_pkg::PH_IDLE)
    else $error("stop not taken");

  a_sda_when_low: assert property (
    $changed(q.sda_oe) |-> $past(fall || start || stop || !active))
    else $error("sda drive changed outside scl low");

  a_read_dir: assert property (
    (active && !start && !stop && fall && q.bcnt == 4'h8 &&
     q.ph == ics_pkg::PH_ADDR && q.rd)
    |=> q.ph == ics_pkg::PH_RD && q.sda_oe == !q.tx[7])
    else $error("read request not served");

  a_off_quiet: assert property (
    !en_s |=> !q.sda_oe && !q.loaded)
    else $error("bus driven while disabled");

  a_reg_then_data: assert property (
    (active && !start && !stop && fall && q.bcnt == 4'h8 &&
     q.ph == ics_pkg::PH_REG) |=> q.ph == ics_pkg::PH_DATA ##0 q.bcnt == 4'h0)
    else $error("data phase not entered");

  c_write: cover property (byte_end && q.ph == ics_pkg::PH_DATA);
  c_read: cover property (q.ph == ics_pkg::PH_RD && fall && q.bcnt == 4'h8);
  c_nack: cover property (byte_end && q.ph == ics_pkg::PH_ADDR &&
                          q.sh[7:1] != my_addr);
  c_load: cover property (ld_done ##1 q.loaded);

endmodule

// [hw/ics_pkg.sv]
// Shared constants and types of the I2C configuration slave with its
// one-time-programmable loader.
// Assumes a single 100 MHz system clock and an AXI4-Lite register master.
package ics_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          CFG_REGS    = 8;
  localparam int          IDX_W       = 3;
  localparam int          AXI_AW      = 8;
  // Config byte n sits at OFF_CFG0 + 4*n, up to OFF_STAT
  localparam logic [7:0]  OFF_CFG0    = 8'h00;
  localparam logic [7:0]  OFF_STAT    = 8'h20;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Config bytes, fields and reset values
  // ----------------------------------------------------------------
  localparam int          REG_VOUT      = 0;
  localparam int          REG_DITH      = 1;
  localparam int          DITH_WIDE_BIT = 0;
  localparam int          DITH_SLOW_BIT = 1;
  localparam logic [7:0]  VOUT_5V_RST   = 8'h64;
  localparam logic [7:0]  DITH_RST      = 8'h00;
  // Status word: loaded 0, loading 1, busy 2, address 14:8, page 17:16
  localparam int          ST_ADDR_LSB   = 8;
  localparam int          ST_PAGE_LSB   = 16;

  // ----------------------------------------------------------------
  // Addressing and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  ADDR_BASE      = 7'h21;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          DITH_SHORT_US  = 120;
  localparam int          DITH_LONG_US   = 150;
  localparam int          DITH_SHORT_CYC = DITH_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int          DITH_LONG_CYC  = DITH_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int          OTP_PAGES      = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_REG, PH_DATA, PH_RD, PH_SKIP
  } ics_phase_type;

  typedef enum logic [1:0] {LD_IDLE, LD_ADDR, LD_DATA} ics_ld_st_type;

  typedef struct packed {
    logic [1:0]       page;
    logic [IDX_W-1:0] word;
  } ics_otp_rq_type;

  typedef struct packed {
    logic             en;
    logic [IDX_W-1:0] idx;
    logic [7:0]       data;
  } ics_wr_type;

  typedef struct packed {
    ics_ld_st_type    st;
    logic [1:0]       page;
    logic [IDX_W-1:0] word;
    logic             busy;
    logic             done;
  } ics_ld_type;

  typedef struct packed {
    logic [1:0]                 scl_sy;
    logic [1:0]                 sda_sy;
    logic                       scl_p;
    logic                       sda_p;
    logic [1:0]                 en_sy;
    logic                       en_p;
    logic [5:0]                 asel_sy;
    ics_phase_type              ph;
    logic [3:0]                 bcnt;
    logic [7:0]                 sh;
    logic [7:0]                 tx;
    logic [7:0]                 ptr;
    logic                       rd;
    logic                       sda_oe;
    logic                       busy;
    logic                       loaded;
    logic [CFG_REGS-1:0][7:0]   cfg;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [1:0]                 rresp;
    logic [31:0]                rdata;
  } ics_st_type;

  // Strap range code 0..7 picks the addresses in ascending order
  function automatic logic [6:0] strap_addr(input logic [2:0] code);
    return ADDR_BASE + {4'h0, code};
  endfunction

endpackage

// [hw/ics_otp_loader.sv]
// Copies a one-time-programmable page set into the config bytes.
// Assumes a synchronous OTP read port: data valid one cycle after address.
`timescale 1ns/1ps
module ics_otp_loader (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  go,
  output      logic                  busy,
  output      logic                  done,
  output      logic [1:0]            page_sel,
  // OTP read port; page_used[0] is page 1, page_used[1] is page 2
  input  wire logic [1:0]            page_used,
  output      ics_pkg::ics_otp_rq_type otp_rq,
  input  wire logic [7:0]            otp_rdata,
  // Config byte write
  output      ics_pkg::ics_wr_type   wr
);

  ics_pkg::ics_ld_type q;
  ics_pkg::ics_ld_type d;
  logic [1:0]          newest;

  assign newest = page_used[1] ? 2'h2 : (page_used[0] ? 2'h1 : 2'h0);

  always_comb begin
    d      = q;
    d.done = 1'b0;
    case (q.st)
      ics_pkg::LD_ADDR: begin
        d.st = ics_pkg::LD_DATA;
      end
      ics_pkg::LD_DATA: begin
        if (q.word == 3'(ics_pkg::CFG_REGS - 1)) begin
          if (q.page == 2'h0 && newest != 2'h0) begin
            d.page = newest;
            d.word = '0;
            d.st   = ics_pkg::LD_ADDR;
          end else begin
            d.st   = ics_pkg::LD_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        end else begin
          d.word = q.word + 3'h1;
          d.st   = ics_pkg::LD_ADDR;
        end
      end
      default: begin
        d.st = ics_pkg::LD_IDLE;
      end
    endcase
    if (go) begin
      d.st   = ics_pkg::LD_ADDR;
      d.page = 2'h0;
      d.word = '0;
      d.busy = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign otp_rq.page = q.page;
  assign otp_rq.word = q.word;
  assign wr.en       = (q.st == ics_pkg::LD_DATA);
  assign wr.idx      = q.word;
  assign wr.data     = otp_rdata;
  assign busy        = q.busy;
  assign done        = q.done;
  assign page_sel    = q.page;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_newest_page: assert property (
    (q.st == ics_pkg::LD_DATA && q.page == 2'h0 && newest != 2'h0 &&
     q.word == 3'(ics_pkg::CFG_REGS - 1) && !go)
    |=> q.page == $past(newest) && q.word == 3'h0 && q.busy)
    else $error("loader did not switch to newest page");

  a_load_len: assert property (
    (go && newest == 2'h0) ##1 (!go) [*8] |-> ##[1:9] done)
    else $error("factory load did not finish in time");

endmodule

// [tb/ics_i2c_master.sv]
// I2C master model: 80 ns bit period, open-drain data.
// Assumes the bench resolves sda with a pull-up.
`timescale 1ns/1ps
module ics_i2c_master (
  // Link
  output logic      scl = 1'b1,
  output logic      sda_low = 1'b0,
  input  wire logic sda
);
  // data moves with clock low
  // Non-blocking so that edges landing on mclk edges do not race it
  task automatic pulse(input logic b, output logic r);
    sda_low <= !b;
    #40 scl <= 1'b1;
    #15 r = sda;
    #15 scl <= 1'b0;
    #10;
  endtask
  task automatic start();
    sda_low <= 1'b0;
    #20 scl <= 1'b1;
    #40 sda_low <= 1'b1;
    #40 scl <= 1'b0;
    #10;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    #20 scl <= 1'b1;
    #40 sda_low <= 1'b0;
    #4700;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) pulse(d[i], q[i]);
    pulse(ab, a);
    ack = !a;
  endtask
endmodule

// [tb/i2c_config_slave_otp_loader_tb_top.sv]
// Bench of the I2C configuration slave, OTP load and AXI access.
// Assumes the master model and a patterned OTP read port.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module i2c_config_slave_otp_loader_tb_top;
  logic        mclk = 1'b0, rst = 1'b1, en_pin = 1'b0;
  logic [1:0]  pu = 2'b01;
  logic [7:0]  otp_rdata, aw = 8'h00, ar = 8'h00, vout, q;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic        scl, m_low, sda_oe, awr, wr, bv, arr, rv, wide, ack;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] per;
  int          num_errors = 0, compares = 0;
  wire         sda = !(m_low | sda_oe);
  ics_pkg::ics_otp_rq_type otp_rq;
  logic [7:0]  row_reg [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
  logic [7:0]  row_dat [4] = '{8'h00, 8'h02, 8'h5a, 8'h03};
  logic        row_wide [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic        row_slow [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

  always #5 mclk = ~mclk;
  // Each OTP byte holds its own page and word number
  always @(posedge mclk) otp_rdata <= {3'h0, otp_rq};

  ics_i2c_master u_ics_i2c_master (.scl(scl), .sda_low(m_low), .sda(sda));
  ics_cfg_slave u_ics_cfg_slave (
    .mclk(mclk), .rst(rst), .en_pin(en_pin), .addr_sel(3'h3),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .otp_page_used(pu), .otp_rq(otp_rq), .otp_rdata(otp_rdata),
    .vout_code(vout), .dith_wide(wide), .dith_period_cyc(per),
    .axi_awaddr(aw), .axi_awvalid(awv), .axi_awready(awr),
    .axi_wdata(wd), .axi_wstrb(4'hf), .axi_wvalid(wv), .axi_wready(wr),
    .axi_bresp(bresp), .axi_bvalid(bv), .axi_bready(bry),
    .axi_araddr(ar), .axi_arvalid(arv), .axi_arready(arr),
    .axi_rdata(rdat), .axi_rresp(rresp), .axi_rvalid(rv),
    .axi_rready(rry));

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    aw  <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do @(posedge mclk); while (!(awr && wr));
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(posedge mclk); while (!bv);
    rsp = bresp;
    bry <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    ar  <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge mclk); while (!arr);
    arv <= 1'b0;
    do @(posedge mclk); while (!rv);
    rsp = rresp;
    rd  = rdat;
    rry <= 1'b0;
  endtask

  task automatic ping(input logic [7:0] a, input logic e);
    u_ics_i2c_master.start();
    u_ics_i2c_master.xfer(a, 1'b1, q, ack);
    `CHK(ack, e)
  endtask

  // Polls status until loaded; gives up after 100 status reads
  task automatic wait_loaded();
    repeat (100) begin
      axi_rd(ics_pkg::OFF_STAT);
      if (rd[0]) break;
    end
  endtask

  task automatic summarize();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK(vout, ics_pkg::VOUT_5V_RST)
    ping({7'h24, 1'b0}, 1'b0);
    u_ics_i2c_master.stop();
    $display("test disabled done");
    en_pin <= 1'b1;
    wait_loaded();
    `CHK(rd[14:8], 7'h24)
    `CHK({vout, wide}, {8'h08, 1'b1})
    $display("test load done");
    foreach (row_reg[i]) begin
      ping({7'h24, 1'b0}, 1'b1);
      u_ics_i2c_master.xfer(row_reg[i], 1'b1, q, ack);
      `CHK(ack, 1'b1)
      u_ics_i2c_master.xfer(row_dat[i], 1'b1, q, ack);
      `CHK(ack, 1'b1)
      u_ics_i2c_master.stop();
      axi_rd({row_reg[i][5:0], 2'b00});
      `CHK(rd, {24'h0, row_dat[i]})
      `CHK(wide, row_wide[i])
      `CHK(per, 16'(row_slow[i] ? ics_pkg::DITH_LONG_CYC
                               : ics_pkg::DITH_SHORT_CYC))
    end
    `CHK(vout, 8'h5a)
    $display("test rows done");
    ping({7'h21, 1'b0}, 1'b0);
    ping({7'h24, 1'b1}, 1'b1);
    u_ics_i2c_master.xfer(8'hff, 1'b1, q, ack);
    `CHK(q, 8'h03)
    u_ics_i2c_master.stop();
    $display("test read done");
    axi_wr(8'h28, 32'h0);
    `CHK(rsp, ics_pkg::RESP_SLVERR)
    axi_rd(8'h24);
    `CHK({rsp, rd}, {ics_pkg::RESP_SLVERR, 32'h0})
    axi_wr(ics_pkg::OFF_CFG0, 32'h33);
    `CHK(vout, 8'h33)
    $display("test axi done");
    // Mid-run reset with a factory-only load, then a page-2 load
    pu  <= 2'b00;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(vout, ics_pkg::VOUT_5V_RST)
    rst <= 1'b0;
    wait_loaded();
    `CHK({vout, wide}, {8'h00, 1'b1})
    en_pin <= 1'b0;
    pu     <= 2'b10;
    repeat (4) @(posedge mclk);
    en_pin <= 1'b1;
    wait_loaded();
    `CHK({rd[17:16], vout}, {2'h2, 8'h10})
    $display("test reload done");
    summarize();
  end
endmodule
